// ==== shared/fsoc_regs.svh ====
`ifndef FSOC_REGS_SVH
`define FSOC_REGS_SVH

// Register indices; the byte address is four times the index.
`define FSOC_IDX_PULSE_CFG 10'h07A
`define FSOC_IDX_PHASE_CFG 10'h07B
`define FSOC_IDX_STATUS 10'h07E
`define FSOC_ADDR_PULSE_CFG 12'h1E8
`define FSOC_ADDR_PHASE_CFG 12'h1EC
`define FSOC_ADDR_STATUS 12'h1F8

`define FSOC_PULSE_CFG_RST 8'h00
`define FSOC_PHASE_CFG_RST 8'h00
`define FSOC_PULSE_CFG_MASK 8'h8F
`define FSOC_PHASE_CFG_MASK 8'hC3

// Field positions in the pulse configuration register.
`define FSOC_BIT_MF_PULSE 0
`define FSOC_BIT_MF_INVERT 1
`define FSOC_BIT_FR_PULSE 2
`define FSOC_BIT_FR_INVERT 3
`define FSOC_BIT_FROM_ALT 7

// Field positions in the phase configuration register.
`define FSOC_BIT_OFFSET_LO 0
`define FSOC_BIT_OFFSET_HI 1
`define FSOC_BIT_FAST_SAMPLE 6
`define FSOC_BIT_INDEPENDENT 7

// Taps of the sample delay line, in half unit intervals.
`define FSOC_TAP_EARLY 3'h1
`define FSOC_TAP_TARGET 3'h2
`define FSOC_TAP_HALF_LATE 3'h3
`define FSOC_TAP_ONE_LATE 3'h4
`define FSOC_DELAY_DEPTH 5

// Half frame periods in one multiframe period.
`define FSOC_HALVES_PER_MF 8

`endif

// ==== shared/fsoc_pkg.sv ====
package fsoc_pkg;

    typedef enum logic [1:0] {
        FSOC_RATE_6M48 = 2'b00,
        FSOC_RATE_19M44 = 2'b01,
        FSOC_RATE_38M88 = 2'b10
    } fsoc_rate_t;

    typedef enum logic [1:0] {
        FSOC_OFS_TARGET = 2'b00,
        FSOC_OFS_HALF_EARLY = 2'b01,
        FSOC_OFS_ONE_LATE = 2'b10,
        FSOC_OFS_HALF_LATE = 2'b11
    } fsoc_offset_t;

    typedef struct packed {
        logic sync_level;
        logic pulse_blocked;
        fsoc_rate_t rate;
    } fsoc_status_t;

endpackage : fsoc_pkg

// ==== verilog/fsoc_top.sv ====
// Notes on behaviour
// - Multiframe output is a 50:50 square wave, or pulses when pulse mode is set.
// - Pulse mode only works with clock output three enabled; else square wave.
// - Each pulse lasts exactly one period of clock output three.
// - Independence clear: sync realignment also realigns the other output clocks.
// - Independence set: sync outputs realign alone, other clocks undisturbed.
// - Fast sampling set: sync input sampled with a 19.44 or 38.88 MHz reference.
// - Fast sampling uses 19.44 MHz if current reference is 19.44, else 38.88.
// - Offset field shifts sampling: on target, half early, one late, half late.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "fsoc_regs.svh"

module fsoc_top (
    input wire logic REF_CLK, // System clock, 125 MHz.
    input wire logic RESET, // Synchronous reset, active high.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB access phase.
    input wire logic PWRITE, // APB direction, high for write.
    input wire logic [11:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    output logic [31:0] PRDATA, // APB read data.
    output logic PREADY, // APB ready.
    output logic PSLVERR, // APB error on unmapped address.
    input wire logic [2:0] HALF_UI_STB, // Half unit interval strobes: 6.48, 19.44, 38.88 MHz.
    input wire logic REF_IS_19M44, // Current input reference is 19.44 MHz, asynchronous.
    input wire logic EXTERNAL_SYNC_INPUT, // External 2 kHz sync, asynchronous.
    input wire logic FRAME_HALF_TICK, // Strobe at each half of the 8 kHz frame period.
    input wire logic CLK3_EDGE, // Strobe once per period of clock output three.
    input wire logic CLK3_ENABLED, // Clock output three is enabled.
    output logic FRAME_SYNC_OUT, // 8 kHz frame sync.
    output logic MULTIFRAME_SYNC_OUT, // 2 kHz multiframe sync.
    output logic ALIGN_OTHER_CLOCKS, // One-cycle request to realign the other output clocks.
    output logic [1:0] SAMPLE_RATE_SEL // Selected sampling rate code.
);

    logic [7:0] pulse_cfg_r;
    logic [7:0] phase_cfg_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [2:0] ref_sync_r;
    logic [2:0] ext_sync_r;
    logic ref_19m44_r;
    logic ext_level_r;
    logic [`FSOC_DELAY_DEPTH-1:0] delay_line_r;
    logic sampled_r;
    logic [2:0] half_cnt_r;
    logic fr_pending_r;
    logic mf_pending_r;
    logic fr_pulse_r;
    logic mf_pulse_r;
    logic frame_out_r;
    logic mf_out_r;
    logic align_r;
    fsoc_pkg::fsoc_rate_t rate_r;

    wire access_w = PSEL && PENABLE;
    wire done_w = access_w && pready_r;
    wire hit_pulse_w = (PADDR == `FSOC_ADDR_PULSE_CFG);
    wire hit_phase_w = (PADDR == `FSOC_ADDR_PHASE_CFG);
    wire hit_status_w = (PADDR == `FSOC_ADDR_STATUS);
    wire mapped_w = hit_pulse_w || hit_phase_w || hit_status_w;
    wire wr_pulse_w = done_w && PWRITE && hit_pulse_w;
    wire wr_phase_w = done_w && PWRITE && hit_phase_w;

    wire mf_pulse_mode_w = pulse_cfg_r[`FSOC_BIT_MF_PULSE];
    wire fr_pulse_mode_w = pulse_cfg_r[`FSOC_BIT_FR_PULSE];
    wire independent_w = phase_cfg_r[`FSOC_BIT_INDEPENDENT];
    wire fast_sample_w = phase_cfg_r[`FSOC_BIT_FAST_SAMPLE];
    wire [1:0] offset_w = phase_cfg_r[`FSOC_BIT_OFFSET_HI:`FSOC_BIT_OFFSET_LO];

    wire fsoc_pkg::fsoc_rate_t rate_nxt = !fast_sample_w ? fsoc_pkg::FSOC_RATE_6M48 :
        (ref_19m44_r ? fsoc_pkg::FSOC_RATE_19M44 : fsoc_pkg::FSOC_RATE_38M88);
    wire sample_stb_w = HALF_UI_STB[rate_r];

    // The five-stage delay line lets the offset move sampling before and after target;
    // the early tap exists only because target itself sits two strobes deep.
    // sampling offset tap
    wire [2:0] tap_w = (offset_w == fsoc_pkg::FSOC_OFS_HALF_EARLY) ? `FSOC_TAP_EARLY :
        (offset_w == fsoc_pkg::FSOC_OFS_ONE_LATE) ? `FSOC_TAP_ONE_LATE :
        (offset_w == fsoc_pkg::FSOC_OFS_HALF_LATE) ? `FSOC_TAP_HALF_LATE : `FSOC_TAP_TARGET;
    wire tapped_w = delay_line_r[tap_w];
    wire sync_event_w = sample_stb_w && tapped_w && !sampled_r;

    // A sync event restarts the multiframe at half zero.
    // A half tick that meets a sync event is dropped, since the restart supersedes it.
    wire [2:0] half_nxt = sync_event_w ? 3'h0 :
        (FRAME_HALF_TICK ? half_cnt_r + 3'h1 : half_cnt_r);
    wire mf_start_w = (sync_event_w || FRAME_HALF_TICK) && (half_nxt == 3'h0);
    wire fr_start_w = (sync_event_w || FRAME_HALF_TICK) && !half_nxt[0];

    // Without clock three there is no width to borrow for a pulse, so the output falls back
    // to the square wave and the status register shows the blocked request.
    // pulse needs clock three
    wire mf_pulsed_w = mf_pulse_mode_w && CLK3_ENABLED;
    wire fr_pulsed_w = fr_pulse_mode_w && CLK3_ENABLED;

    wire mf_level_w = mf_pulsed_w ? mf_pulse_r : !half_cnt_r[2];
    wire fr_level_w = fr_pulsed_w ? fr_pulse_r : !half_cnt_r[0];

    fsoc_pkg::fsoc_status_t status_w;
    assign status_w = '{sync_level: sampled_r, pulse_blocked: (mf_pulse_mode_w || fr_pulse_mode_w) && !CLK3_ENABLED,
        rate: rate_r};

    // Read data is forced to zero outside the answer cycle, so no stale byte lingers on the bus.
    wire [7:0] rd_byte_w = hit_pulse_w ? pulse_cfg_r : hit_phase_w ? phase_cfg_r :
        hit_status_w ? {4'h0, status_w} : 8'h00;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            // One wait state: ready rises in the second access cycle.
            pready_r <= access_w && !pready_r;
            pslverr_r <= access_w && !pready_r && !mapped_w;
            prdata_r <= (access_w && !pready_r && !PWRITE) ? {24'h000000, rd_byte_w} : 32'h00000000;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pulse_cfg_r <= `FSOC_PULSE_CFG_RST;
            phase_cfg_r <= `FSOC_PHASE_CFG_RST;
        end else begin
            if (wr_pulse_w) begin
                pulse_cfg_r <= PWDATA[7:0] & `FSOC_PULSE_CFG_MASK;
            end
            if (wr_phase_w) begin
                phase_cfg_r <= PWDATA[7:0] & `FSOC_PHASE_CFG_MASK;
            end
        end
    end

    // A level is accepted only once the second and third stages agree.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ref_sync_r <= 3'h0;
            ext_sync_r <= 3'h0;
            ref_19m44_r <= 1'b0;
            ext_level_r <= 1'b0;
        end else begin
            ref_sync_r <= {ref_sync_r[1:0], REF_IS_19M44};
            ext_sync_r <= {ext_sync_r[1:0], EXTERNAL_SYNC_INPUT};
            if (ref_sync_r[1] == ref_sync_r[2]) begin
                ref_19m44_r <= ref_sync_r[2];
            end
            if (ext_sync_r[1] == ext_sync_r[2]) begin
                ext_level_r <= ext_sync_r[2];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rate_r <= fsoc_pkg::FSOC_RATE_6M48;
            delay_line_r <= '0;
            sampled_r <= 1'b0;
        end else begin
            rate_r <= rate_nxt;
            if (sample_stb_w) begin
                delay_line_r <= {delay_line_r[`FSOC_DELAY_DEPTH-2:0], ext_level_r};
                sampled_r <= tapped_w;
            end
        end
    end

    // A boundary only arms the pulse; the next clock-three edge raises it and the one after
    // lowers it, so the width is always one whole clock-three period.
    // The pulse logic runs in every mode, so a switch into pulse mode may show a pulse at once.
    // pulse width of clock three
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            half_cnt_r <= 3'h0;
            fr_pending_r <= 1'b0;
            mf_pending_r <= 1'b0;
            fr_pulse_r <= 1'b0;
            mf_pulse_r <= 1'b0;
        end else begin
            half_cnt_r <= half_nxt;
            if (mf_start_w) begin
                mf_pending_r <= 1'b1;
            end else if (CLK3_EDGE) begin
                mf_pending_r <= 1'b0;
            end
            if (fr_start_w) begin
                fr_pending_r <= 1'b1;
            end else if (CLK3_EDGE) begin
                fr_pending_r <= 1'b0;
            end
            if (CLK3_EDGE) begin
                mf_pulse_r <= mf_pending_r;
                fr_pulse_r <= fr_pending_r;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            frame_out_r <= 1'b0;
            mf_out_r <= 1'b0;
            align_r <= 1'b0;
        end else begin
            frame_out_r <= fr_level_w ^ pulse_cfg_r[`FSOC_BIT_FR_INVERT];
            mf_out_r <= mf_level_w ^ pulse_cfg_r[`FSOC_BIT_MF_INVERT];
            // Independent outputs never disturb the other clocks, at the cost of no shared phase.
            // realign others only when tied
            align_r <= sync_event_w && !independent_w;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign FRAME_SYNC_OUT = frame_out_r;
    assign MULTIFRAME_SYNC_OUT = mf_out_r;
    assign ALIGN_OTHER_CLOCKS = align_r;
    assign SAMPLE_RATE_SEL = rate_r;

endmodule : fsoc_top

// ==== dv/fsoc_properties.sv ====
`timescale 1ns/10ps
`include "fsoc_regs.svh"

module fsoc_checker (
    input wire logic REF_CLK, // Clock.
    input wire logic RESET, // Reset.
    input wire logic PSEL, // Select.
    input wire logic PENABLE, // Access.
    input wire logic PWRITE, // Write.
    input wire logic [11:0] PADDR, // Address.
    input wire logic [31:0] PWDATA, // Write data.
    input wire logic [31:0] PRDATA, // Read data.
    input wire logic PREADY, // Ready.
    input wire logic PSLVERR, // Error.
    input wire logic REF_IS_19M44, // Reference rate.
    input wire logic CLK3_EDGE, // Clock three edge.
    input wire logic CLK3_ENABLED, // Clock three on.
    input wire logic MULTIFRAME_SYNC_OUT, // Multiframe sync.
    input wire logic ALIGN_OTHER_CLOCKS, // Realign request.
    input wire logic [1:0] SAMPLE_RATE_SEL // Rate code.
);
    logic [7:0] pulse_r;
    logic [7:0] phase_r;
    wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
    // Shadow copies of the configuration, so mode-dependent checks need no internal probes.
    always_ff @(posedge REF_CLK) begin
        if (RESET) pulse_r <= 8'h00;
        else if (wr_done && PADDR == `FSOC_ADDR_PULSE_CFG) pulse_r <= PWDATA[7:0] & `FSOC_PULSE_CFG_MASK;
    end
    always_ff @(posedge REF_CLK) begin
        if (RESET) phase_r <= 8'h00;
        else if (wr_done && PADDR == `FSOC_ADDR_PHASE_CFG) phase_r <= PWDATA[7:0] & `FSOC_PHASE_CFG_MASK;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    property p_ready_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    property p_ready_once; PREADY |=> !PREADY; endproperty
    property p_err_zero; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
    property p_rate_legal; SAMPLE_RATE_SEL != 2'h3; endproperty
    property p_rate_slow; !phase_r[6] && $stable(phase_r[6]) |=> SAMPLE_RATE_SEL == 2'h0; endproperty
    property p_rate_fast; (phase_r[6] && REF_IS_19M44) [*8] |=> SAMPLE_RATE_SEL == 2'h1; endproperty
    property p_align_one; ALIGN_OTHER_CLOCKS |=> !ALIGN_OTHER_CLOCKS; endproperty
    property p_indep_quiet; phase_r[7] [*3] |-> !ALIGN_OTHER_CLOCKS; endproperty
    property p_pulse_start;
        pulse_r[1:0] == 2'h1 && $past(pulse_r[1:0], 2) == 2'h1 && CLK3_ENABLED && $rose(MULTIFRAME_SYNC_OUT)
            |-> $past(CLK3_EDGE, 2);
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready missing after one wait state");
    a_ready_once: assert property (p_ready_once) else $error("ready held too long");
    a_err_zero: assert property (p_err_zero) else $error("error answer malformed");
    a_rate_legal: assert property (p_rate_legal) else $error("illegal rate code");
    a_rate_slow: assert property (p_rate_slow) else $error("slow rate not selected");
    a_rate_fast: assert property (p_rate_fast) else $error("fine rate not selected");
    a_align_one: assert property (p_align_one) else $error("realign request too long");
    a_indep_quiet: assert property (p_indep_quiet) else $error("realign while independent");
    a_pulse_start: assert property (p_pulse_start) else $error("pulse rise without clock three edge");
    c_pulse: cover property ($rose(MULTIFRAME_SYNC_OUT) && pulse_r[0]);
    c_align: cover property (ALIGN_OTHER_CLOCKS);
    c_err: cover property (PSLVERR);
endmodule : fsoc_checker

bind fsoc_top fsoc_checker u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .REF_IS_19M44(REF_IS_19M44), .CLK3_EDGE(CLK3_EDGE), .CLK3_ENABLED(CLK3_ENABLED),
    .MULTIFRAME_SYNC_OUT(MULTIFRAME_SYNC_OUT), .ALIGN_OTHER_CLOCKS(ALIGN_OTHER_CLOCKS),
    .SAMPLE_RATE_SEL(SAMPLE_RATE_SEL));

// ==== dv/fsoc_partner.sv ====
`timescale 1ns/10ps

module fsoc_partner #(parameter int HALF = 20, parameter int C3 = 6) (
    input wire logic clk, // System clock.
    input wire logic reset, // Synchronous reset.
    input wire logic mf_sync, // Multiframe sync from the block.
    input wire logic fr_sync, // Frame sync from the block.
    output logic half_tick, // Half frame strobe.
    output logic clk3_edge, // Clock three strobe.
    output logic [2:0] ui_stb, // Half unit interval strobes.
    output logic [15:0] mf_width, // Last multiframe high time.
    output logic [15:0] fr_width // Last frame high time.
);
    logic [15:0] cnt_r = 16'h0;
    logic [15:0] hi_r = 16'h0;
    logic [15:0] fr_hi_r = 16'h0;
    initial mf_width = 16'h0;
    initial fr_width = 16'h0;
    // The consumer only reports whole pulses, so a pulse cut by a mode change is overwritten later.
    always @(posedge clk) begin
        cnt_r <= reset ? 16'h0 : cnt_r + 16'h1;
        hi_r <= mf_sync ? hi_r + 16'h1 : 16'h0;
        if (!mf_sync && hi_r != 16'h0) mf_width <= hi_r;
        fr_hi_r <= fr_sync ? fr_hi_r + 16'h1 : 16'h0;
        if (!fr_sync && fr_hi_r != 16'h0) fr_width <= fr_hi_r;
    end
    assign half_tick = (cnt_r % 16'(HALF)) == 16'h0;
    assign clk3_edge = (cnt_r % 16'(C3)) == 16'h3;
    assign ui_stb = {cnt_r[0], cnt_r[1:0] == 2'h1, cnt_r[2:0] == 3'h2};
endmodule : fsoc_partner

// ==== dv/test_fsoc_top.sv ====
`timescale 1ns/10ps
`include "fsoc_regs.svh"

module test_fsoc_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic ref19 = 1'b0;
    logic ext = 1'b0;
    logic c3en = 1'b0;
    logic [31:0] prd;
    logic rdy, err, half_tick, c3_edge, mf, align;
    logic [2:0] ui_stb;
    logic [1:0] rate;
    logic [15:0] mf_w;
    logic [15:0] fr_w;
    logic fs;
    logic [31:0] q;
    logic e;
    int n_errors = 0;
    int comparisons = 0;
    int n_align = 0;
    int k;
    int lat;
    always #4 clk = ~clk;
    always @(posedge clk) if (align === 1'b1) n_align++;
    fsoc_partner #(.HALF(20), .C3(6)) u_far (.clk(clk), .reset(rst), .mf_sync(mf), .fr_sync(fs),
        .half_tick(half_tick), .clk3_edge(c3_edge), .ui_stb(ui_stb), .mf_width(mf_w), .fr_width(fr_w));
    fsoc_top DUT (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .HALF_UI_STB(ui_stb), .REF_IS_19M44(ref19),
        .EXTERNAL_SYNC_INPUT(ext), .FRAME_HALF_TICK(half_tick), .CLK3_EDGE(c3_edge), .CLK3_ENABLED(c3en),
        .FRAME_SYNC_OUT(fs), .MULTIFRAME_SYNC_OUT(mf), .ALIGN_OTHER_CLOCKS(align), .SAMPLE_RATE_SEL(rate));
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask : rd
    task automatic mf_width_is(input logic [7:0] pc, input logic en, input logic [15:0] exp,
        input logic [15:0] fr_exp, input string name);
        c3en <= en;
        apb(1'b1, `FSOC_ADDR_PULSE_CFG, {24'h0, pc});
        repeat (400) @(posedge clk);
        chk(name, {16'h0, exp}, {16'h0, mf_w});
        chk({name, " frame"}, {16'h0, fr_exp}, {16'h0, fr_w});
    endtask : mf_width_is
    task automatic sync_event(input logic [7:0] ph, input int exp, input int lat_exp);
        apb(1'b1, `FSOC_ADDR_PHASE_CFG, {24'h0, ph});
        // Start on a slow strobe so the delay through the synchroniser and the taps is fixed.
        do @(posedge clk); while (ui_stb[0] !== 1'b1);
        k = n_align;
        lat = 0;
        ext <= 1'b1;
        for (int t = 1; t <= 150; t++) begin
            @(posedge clk);
            if (align === 1'b1 && lat == 0) lat = t;
        end
        ext <= 1'b0;
        repeat (150) @(posedge clk);
        chk("realign count", 32'(exp), 32'(n_align - k));
        if (exp != 0) chk("realign delay", 32'(lat_exp), 32'(lat));
    endtask : sync_event
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(`FSOC_ADDR_PULSE_CFG, 32'h0, "pulse cfg reset");
        rd(`FSOC_ADDR_PHASE_CFG, 32'h0, "phase cfg reset");
        apb(1'b1, `FSOC_ADDR_PULSE_CFG, 32'hFFFFFFFF);
        rd(`FSOC_ADDR_PULSE_CFG, 32'h8F, "pulse cfg mask");
        apb(1'b1, `FSOC_ADDR_PHASE_CFG, 32'hFFFFFFFF);
        rd(`FSOC_ADDR_PHASE_CFG, 32'hC3, "phase cfg mask");
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        apb(1'b1, `FSOC_ADDR_PHASE_CFG, 32'h40);
        ref19 <= 1'b1;
        repeat (20) @(posedge clk);
        chk("rate fine", 32'h1, {30'h0, rate});
        ref19 <= 1'b0;
        repeat (20) @(posedge clk);
        chk("rate finest", 32'h2, {30'h0, rate});
        apb(1'b1, `FSOC_ADDR_PHASE_CFG, 32'h0);
        repeat (5) @(posedge clk);
        chk("rate slow", 32'h0, {30'h0, rate});
        mf_width_is(8'h00, 1'b1, 16'h0050, 16'h0014, "square width");
        mf_width_is(8'h01, 1'b1, 16'h0006, 16'h0014, "pulse width");
        mf_width_is(8'h01, 1'b0, 16'h0050, 16'h0014, "fallback width");
        rd(`FSOC_ADDR_STATUS, 32'h4, "status");
        apb(1'b1, `FSOC_ADDR_PULSE_CFG, 32'h0);
        mf_width_is(8'h05, 1'b1, 16'h0006, 16'h0006, "both pulsed");
        apb(1'b1, `FSOC_ADDR_PULSE_CFG, 32'h0);
        // Accepted four edges after the rise, then one eight-cycle slow strobe per tap stage.
        sync_event(8'h00, 1, 33);
        sync_event(8'h01, 1, 25);
        sync_event(8'h02, 1, 49);
        sync_event(8'h03, 1, 41);
        sync_event(8'h80, 0, 0);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule : test_fsoc_top
